// file: src/acc_top.sv
// Digital control around an on-chip analog comparator.
// Assumes the analog core acts on the select outputs and gives a raw result.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module acc_top (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rstn_i,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic      [1:0]  avs_response_o,
   // Analog core
   input  wire logic        cmp_raw_i,
   output logic             comparator_disable_o,
   output logic             bandgap_select_o,
   output logic             neg_sel_pin_o,
   output logic      [2:0]  neg_sel_chan_o,
   // CPU interrupt and timer
   input  wire logic        irq_ack_i,
   output logic             comparator_irq_o,
   output logic             capture_trig_o,
   // Port pins
   input  wire logic [7:0]  port_pin_i,
   output logic      [7:0]  port_pin_o,
   output logic      [7:0]  input_buffer_disable_o,
   // Event interrupt
   output logic             evt_irq_o
);
   logic [7:0] buf_dis_q;
   logic [7:0] ctrl_q;
   logic [7:0] mux_q;
   logic       sync1_q, sync2_q, prev_q;
   logic       flag_q;
   logic [2:0] sts_q, ien_q;
   logic       ack_q;
   logic       access;
   logic       wr_hit, rd_hit;
   logic       ctrl_wr, flag_clr_wr;
   logic       rise, fall, tog, evt_hit;
   logic       mux_path;
   logic [2:0] evt_clr;
   logic       mapped;

   // One wait cycle per access; answer on the second edge
   assign access            = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = access & ~ack_q;
   assign wr_hit            = avs_write_i & ack_q;
   assign rd_hit            = avs_read_i & ack_q;
   assign ctrl_wr           = wr_hit & (avs_address_i == acc_pkg::ACC_OFS_CTRL)
                              & avs_byteenable_i[0];
   assign flag_clr_wr       = ctrl_wr & avs_writedata_i[acc_pkg::ACC_BIT_FLAG];

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access & ~ack_q;
      end
   end

   always_comb begin
      mapped = 1'b1;
      unique case (avs_address_i)
         acc_pkg::ACC_OFS_BUF_DIS, acc_pkg::ACC_OFS_CTRL, acc_pkg::ACC_OFS_MUX,
         acc_pkg::ACC_OFS_IRQ_STS, acc_pkg::ACC_OFS_IRQ_EN,
         acc_pkg::ACC_OFS_IRQ_CLR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Register writes
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         buf_dis_q <= acc_pkg::ACC_RST_BUF_DIS;
         ctrl_q    <= acc_pkg::ACC_RST_CTRL;
         mux_q     <= acc_pkg::ACC_RST_MUX;
         ien_q     <= 3'h0;
      end else if (wr_hit && avs_byteenable_i[0]) begin
         unique case (avs_address_i)
            acc_pkg::ACC_OFS_BUF_DIS: buf_dis_q <= avs_writedata_i[7:0];
            acc_pkg::ACC_OFS_CTRL: begin
               // Output and flag bits are not stored here
               ctrl_q <= avs_writedata_i[7:0] & 8'hCF;
            end
            acc_pkg::ACC_OFS_MUX:    mux_q <= avs_writedata_i[7:0];
            acc_pkg::ACC_OFS_IRQ_EN: ien_q <= avs_writedata_i[2:0];
            default: ;
         endcase
      end
   end

   // Two-flop synchroniser, 1-2 cycle latency
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync1_q <= cmp_raw_i;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // Edges of the synchronised output
   assign tog  = sync2_q ^ prev_q;
   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;

   always_comb begin
      unique case (ctrl_q[1:0])
         acc_pkg::ACC_MODE_TOGGLE:  evt_hit = tog;
         acc_pkg::ACC_MODE_RSVD:    evt_hit = 1'b0;
         acc_pkg::ACC_MODE_FALLING: evt_hit = fall;
         acc_pkg::ACC_MODE_RISING:  evt_hit = rise;
      endcase
   end

   // Comparator flag; a new event wins over any clear
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_q <= 1'b0;
      end else if (evt_hit) begin
         flag_q <= 1'b1;
      end else if (irq_ack_i || flag_clr_wr) begin
         flag_q <= 1'b0;
      end
   end

   // Sticky event status, write-one clear
   assign evt_clr = (wr_hit && avs_byteenable_i[0]
                     && avs_address_i == acc_pkg::ACC_OFS_IRQ_CLR)
                    ? avs_writedata_i[2:0] : 3'h0;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sts_q <= 3'h0;
      end else begin
         sts_q <= (sts_q & ~evt_clr) | {fall, rise, tog};
      end
   end

   // Read data, registered
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         avs_readdata_o <= 32'h0000_0000;
         avs_response_o <= 2'h0;
      end else if (access && !ack_q) begin
         avs_response_o <= mapped ? 2'h0 : 2'h3;
         avs_readdata_o <= 32'h0000_0000;
         if (avs_read_i) begin
            unique case (avs_address_i)
               acc_pkg::ACC_OFS_BUF_DIS: avs_readdata_o[7:0] <= buf_dis_q;
               acc_pkg::ACC_OFS_CTRL: avs_readdata_o[7:0] <=
                  {ctrl_q[7:6], sync2_q, flag_q, ctrl_q[3:0]};
               acc_pkg::ACC_OFS_MUX:     avs_readdata_o[7:0] <= mux_q;
               acc_pkg::ACC_OFS_IRQ_STS: avs_readdata_o[2:0] <= sts_q;
               acc_pkg::ACC_OFS_IRQ_EN:  avs_readdata_o[2:0] <= ien_q;
               default: ;
            endcase
         end
      end
   end

   // Negative input select; codes above 7 fall back to the pin
   assign mux_path = mux_q[acc_pkg::ACC_BIT_MUX_EN] & ~mux_q[acc_pkg::ACC_BIT_CONV_EN]
                     & (mux_q[4:0] <= acc_pkg::ACC_MUX_MAX);
   assign neg_sel_pin_o  = ~mux_path;
   assign neg_sel_chan_o = mux_path ? mux_q[2:0] : 3'h0;

   assign comparator_disable_o = ctrl_q[acc_pkg::ACC_BIT_DISABLE];
   assign bandgap_select_o     = ctrl_q[acc_pkg::ACC_BIT_BANDGAP];
   assign comparator_irq_o     = flag_q & ctrl_q[acc_pkg::ACC_BIT_IE]
                                 & mux_q[acc_pkg::ACC_BIT_GIE];
   assign capture_trig_o       = ctrl_q[acc_pkg::ACC_BIT_CAPTURE] & sync2_q;
   assign input_buffer_disable_o = buf_dis_q;
   assign port_pin_o           = port_pin_i & ~buf_dis_q;
   assign evt_irq_o            = |(sts_q & ien_q);
endmodule
`default_nettype wire

// file: src/acc_pkg.sv
// Constants for the analog comparator control block.
// Assumes a single 25 MHz clock and a 32-bit Avalon-MM register slave.
package acc_pkg;
   // Register offsets (byte addresses, not all word aligned)
   localparam logic [7:0] ACC_OFS_BUF_DIS = 8'h01;
   localparam logic [7:0] ACC_OFS_CTRL    = 8'h08;
   localparam logic [7:0] ACC_OFS_MUX     = 8'h24;
   localparam logic [7:0] ACC_OFS_IRQ_STS = 8'h28;
   localparam logic [7:0] ACC_OFS_IRQ_EN  = 8'h2C;
   localparam logic [7:0] ACC_OFS_IRQ_CLR = 8'h30;
   // Control and status fields
   localparam int ACC_BIT_DISABLE = 7;
   localparam int ACC_BIT_BANDGAP = 6;
   localparam int ACC_BIT_OUT     = 5;
   localparam int ACC_BIT_FLAG    = 4;
   localparam int ACC_BIT_IE      = 3;
   localparam int ACC_BIT_CAPTURE = 2;
   // Mux register fields: code in 4:0, mux enable 5, converter enable 6, global ie 7
   localparam int ACC_BIT_MUX_EN  = 5;
   localparam int ACC_BIT_CONV_EN = 6;
   localparam int ACC_BIT_GIE     = 7;
   localparam logic [4:0] ACC_MUX_MAX = 5'h07;
   // Edge modes
   localparam logic [1:0] ACC_MODE_TOGGLE  = 2'h0;
   localparam logic [1:0] ACC_MODE_RSVD    = 2'h1;
   localparam logic [1:0] ACC_MODE_FALLING = 2'h2;
   localparam logic [1:0] ACC_MODE_RISING  = 2'h3;
   // Reset values
   localparam logic [7:0] ACC_RST_BUF_DIS = 8'h00;
   localparam logic [7:0] ACC_RST_CTRL    = 8'h00;
   localparam logic [7:0] ACC_RST_MUX     = 8'h00;
   // Status events: 0 toggle, 1 rising, 2 falling
   localparam int ACC_NUM_EVT = 3;
endpackage

// file: verif/acc_props.sv
// Port checker for the comparator control block.
// Assumes a bind into acc_top, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module acc_props (
   input wire logic        mclk_i, rstn_i, avs_read_i, avs_waitrequest_o, cmp_raw_i,
   input wire logic        neg_sel_pin_o, irq_ack_i, comparator_irq_o, capture_trig_o,
   input wire logic [7:0]  avs_address_i, port_pin_i, port_pin_o, input_buffer_disable_o,
   input wire logic [31:0] avs_readdata_o,
   input wire logic [1:0]  avs_response_o,
   input wire logic [2:0]  neg_sel_chan_o,
   input wire logic        avs_write_i
);
   // Raw history: five equal samples mean the synchroniser has settled
   logic [4:0] raw_q;
   logic       done;
   logic       calm;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         raw_q <= 5'h00;
      end else begin
         raw_q <= {raw_q[3:0], cmp_raw_i};
      end
   end
   assign done = avs_read_i && !avs_waitrequest_o;
   assign calm = (raw_q == 5'h00) || (raw_q == 5'h1F);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   read_answer_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("read answer late");
   unmapped_resp_a: assert property (done && avs_address_i == 8'h10 |-> avs_response_o == 2'h3)
      else $error("unmapped read accepted");
   neg_default_a: assert property (neg_sel_pin_o |-> neg_sel_chan_o == 3'h0)
      else $error("channel with pin");
   out_sync_a: assert property (done && avs_address_i == 8'h08 && calm |-> avs_readdata_o[5] == raw_q[0])
      else $error("output bit stale");
   irq_cause_a: assert property ($rose(comparator_irq_o) |-> $past(avs_write_i) || !calm)
      else $error("irq without cause");
   ack_clear_a: assert property (irq_ack_i && calm |=> !comparator_irq_o)
      else $error("ack kept flag");
   capture_src_a: assert property (capture_trig_o |-> raw_q[2:0] != 3'h0)
      else $error("capture without output");
   port_mask_a: assert property (port_pin_o == (port_pin_i & ~input_buffer_disable_o))
      else $error("pin mask wrong");
endmodule
bind acc_top acc_props u_props (.*);
`default_nettype wire

// file: verif/acc_core_model.sv
// Behavioural analog comparator core.
// Assumes the bench sets the wanted outcome on lvl_i.
`timescale 1ns/100ps
`default_nettype none
module acc_core_model (
   input  wire logic dis_i,
   input  wire logic bg_i,
   input  wire logic lvl_i,
   output logic      raw_o
);
   // Unpowered core reads low; bandgap sits above every negative input
   assign raw_o = dis_i ? 1'b0 : (bg_i | lvl_i);
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the comparator control block.
// Assumes acc_top, its core model and a 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [7:0] CT = 8'h08, MX = 8'h24, BD = 8'h01, ST = 8'h28, EN = 8'h2C, CL = 8'h30;
   logic mclk_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic irq_ack_i = 1'b0, lvl = 1'b0, wt, cmp_raw_i, avs_waitrequest_o;
   logic comparator_disable_o, bandgap_select_o, neg_sel_pin_o, comparator_irq_o;
   logic capture_trig_o, evt_irq_o;
   logic [7:0] avs_address_i = 8'h00, port_pin_i = 8'h00, port_pin_o, input_buffer_disable_o;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [1:0] avs_response_o, r;
   logic [2:0] neg_sel_chan_o;
   int err_count = 0, checked = 0, cyc = 0;
   acc_top DUT (.*);
   acc_core_model core (.dis_i(comparator_disable_o), .bg_i(bandgap_select_o), .lvl_i(lvl),
      .raw_o(cmp_raw_i));
   always #20 mclk_i = ~mclk_i;
   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, d);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= {24'h000000, d};
      // Hold the request until waitrequest is seen low at a rising edge
      do begin
         @(posedge mclk_i);
         wt = avs_waitrequest_o;
      end while (wt !== 1'b0);
      q = avs_readdata_o;
      r = avs_response_o;
      {avs_read_i, avs_write_i} <= 2'h0;
      @(posedge mclk_i);
   endtask
   // Long enough for two sync stages plus edge detect
   task automatic rs(input logic v);
      lvl <= v;
      repeat (6) @(posedge mclk_i);
   endtask
   task automatic t_regs;
      acc(1'b0, CT, 8'h00);
      chk("ctrl", 32'h0, q);
      chk("neg", 32'h8, {neg_sel_pin_o, neg_sel_chan_o});
      for (int c = 0; c < 9; c++) begin
         acc(1'b1, MX, 8'h20 + 8'(c));
         chk("neg", (c > 7) ? 8 : c, {neg_sel_pin_o, neg_sel_chan_o});
      end
      acc(1'b1, MX, 8'h63);
      chk("neg", 32'h8, {neg_sel_pin_o, neg_sel_chan_o});
      acc(1'b1, CT, 8'hC0);
      chk("pwr", 32'h3, {comparator_disable_o, bandgap_select_o});
      acc(1'b1, CT, 8'h40);
      rs(1'b0);
      acc(1'b0, CT, 8'h00);
      chk("out", 32'h1, q[5]);
      acc(1'b1, CT, 8'h00);
      rs(1'b0);
      $display("regs done");
   endtask
   task automatic t_edge;
      for (int m = 0; m < 4; m++) begin
         acc(1'b1, CT, 8'h10 + 8'(m));
         rs(1'b1);
         acc(1'b0, CT, 8'h00);
         chk("rise", m == 0 || m == 3, q[4]);
         acc(1'b1, CT, 8'h10 + 8'(m));
         rs(1'b0);
         acc(1'b0, CT, 8'h00);
         chk("fall", m == 0 || m == 2, q[4]);
      end
      $display("edge done");
   endtask
   task automatic t_irq;
      acc(1'b1, MX, 8'h80);
      acc(1'b1, CT, 8'h18);
      rs(1'b1);
      chk("irq", 32'h1, comparator_irq_o);
      acc(1'b1, MX, 8'h00);
      chk("irq", 32'h0, comparator_irq_o);
      acc(1'b1, CT, 8'h00);
      acc(1'b1, MX, 8'h80);
      chk("irq", 32'h0, comparator_irq_o);
      acc(1'b1, CT, 8'h08);
      chk("irq", 32'h1, comparator_irq_o);
      irq_ack_i <= 1'b1;
      @(posedge mclk_i);
      irq_ack_i <= 1'b0;
      @(posedge mclk_i);
      chk("ack", 32'h0, comparator_irq_o);
      rs(1'b0);
      acc(1'b1, CT, 8'h18);
      chk("w1c", 32'h0, comparator_irq_o);
      acc(1'b1, CT, 8'h00);
      $display("irq done");
   endtask
   task automatic t_evt;
      acc(1'b1, CL, 8'h07);
      acc(1'b1, EN, 8'h02);
      rs(1'b1);
      chk("evt", 32'h1, evt_irq_o);
      acc(1'b0, ST, 8'h00);
      chk("sts", 32'h3, q);
      acc(1'b1, EN, 8'h00);
      chk("mask", 32'h0, evt_irq_o);
      acc(1'b1, EN, 8'h02);
      acc(1'b1, CL, 8'h02);
      chk("clr", 32'h0, evt_irq_o);
      port_pin_i <= 8'hFF;
      acc(1'b1, BD, 8'h06);
      chk("pins", 32'hF9, port_pin_o);
      acc(1'b1, CT, 8'h04);
      chk("cap", 32'h1, capture_trig_o);
      acc(1'b0, 8'h10, 8'h00);
      chk("unmap", 32'h3, r);
      $display("evt done");
   endtask
   task automatic report_and_stop;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop;
      end
   end
   initial begin
      repeat (12) @(posedge mclk_i);
      rstn_i <= 1'b1;
      @(posedge mclk_i);
      t_regs;
      t_edge;
      t_irq;
      t_evt;
      report_and_stop;
   end
endmodule
`default_nettype wire
